// ==== design/protection_config_registers.sv ====
/*
  Holds the protection setup word, the averaging setup byte and the peak registers, and decodes their
  fields into settings for the analog and fault logic.
  Assumes a command decoder that gives one-cycle write, send-byte and read strobes with a command code,
  and telemetry samples presented with a one-cycle valid.
*/
// Function
// RULE1: Setup word is sixteen bits, read/write, resetting to all zeros.
// RULE2: Only low four averaging bits set report averaging; upper bits have no effect.
// RULE3: Report averaging code n selects two to the n samples.
// RULE4: Averaging bits 5:4 choose startup limit 8A, 12A, 4A, 16A.
// RULE5: Five ten-bit peak registers keep the largest value seen.
// RULE6: Command D5h or reset clears all peak registers; a sample valid in the D5h cycle is loaded instead of zero.
// RULE7: Bits 15:14 select severe deglitch 0, 1, 2 or 10 microseconds.
// RULE8: Bit 13 set disables current conversion.
// RULE9: Bits 12:11 select soft-start delay 0, 10 or 20 milliseconds.
// RULE10: Bits 9:8 select power-good and self-check threshold pairs.
// RULE11: Bit 7 selects severe level 130 or 170 percent.
// RULE12: Current variant: bits 6:5 select moderate overcurrent timeout.
// RULE13: Power variant: bits 6:5 select overpower fault-detect timeout.
// RULE14: Bit 4 set enables input overvoltage protection.
// RULE15: Bits 3:2 select overvoltage threshold 14, 16 or 18 volts.
// RULE16: Bits 1:0 select warning averaging of 1, 2, 4 or 8 samples.
// RULE17: Peaks read at D1h to D4h and FDh as direct values.
// RULE18: Host avoids unused codes and bit 10.
`timescale 1ns/1ps
module protection_config_registers #(
  parameter bit POWER_VARIANT = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_strobe,
  input  wire logic [15:0] wr_data,
  input  wire logic        send_strobe,
  input  wire logic        rd_strobe,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             rd_error,
  input  wire logic        sample_valid,
  input  wire logic [9:0]  vin_sample,
  input  wire logic [9:0]  iout_sample,
  input  wire logic [9:0]  pin_sample,
  input  wire logic [9:0]  temp_sample,
  input  wire logic [9:0]  vout_sample,
  output logic      [11:0] severe_filter_cycles,
  output logic             current_conv_enable,
  output logic      [4:0]  soft_start_delay_ms,
  output logic      [7:0]  good_level_volts,
  output logic      [7:0]  self_check_volts,
  output logic      [7:0]  severe_ratio_pct,
  output logic      [7:0]  moderate_timeout_ms,
  output logic      [6:0]  moderate_timeout_us,
  output logic             input_overvolt_enable,
  output logic      [7:0]  input_overvolt_volts,
  output logic      [3:0]  alert_avg_samples,
  output logic      [15:0] report_avg_samples,
  output logic      [7:0]  startup_current_amps
);

  logic [15:0] setup_r, setup_nxt;
  logic [7:0]  avg_r, avg_nxt;
  logic [9:0]  peak_r [5];
  logic [9:0]  peak_nxt [5];
  logic [9:0]  sample_in [5];
  logic [15:0] rd_data_r, rd_data_nxt;
  logic        rd_valid_r, rd_valid_nxt;
  logic        rd_error_r, rd_error_nxt;

  assign sample_in[0] = vin_sample;
  assign sample_in[1] = iout_sample;
  assign sample_in[2] = pin_sample;
  assign sample_in[3] = temp_sample;
  assign sample_in[4] = vout_sample;

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration writes; the averaging byte keeps all eight bits so the host reads back what it wrote.
  always_comb begin
    setup_nxt = setup_r;
    avg_nxt   = avg_r;
    if (wr_strobe && cmd_code == prot_cfg_pkg::CMD_SETUP) begin
      setup_nxt = wr_data; // RULE1
    end
    if (wr_strobe && cmd_code == prot_cfg_pkg::CMD_AVERAGING) begin
      avg_nxt = wr_data[7:0];
    end
  end

  // Registers the configuration.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      setup_r <= prot_cfg_pkg::SETUP_RST; // RULE1
      avg_r   <= prot_cfg_pkg::AVERAGING_RST;
    end else begin
      setup_r <= setup_nxt;
      avg_r   <= avg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // Each peak tracks its maximum; a sample in the wipe cycle starts the new peak, so it is never lost.
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_peak
      always_comb begin
        peak_nxt[g] = peak_r[g];
        if (send_strobe && cmd_code == prot_cfg_pkg::CMD_PEAK_WIPE) begin
          peak_nxt[g] = sample_valid ? sample_in[g] : prot_cfg_pkg::PEAK_RST; // RULE6
        end else if (sample_valid && sample_in[g] > peak_r[g]) begin
          peak_nxt[g] = sample_in[g]; // RULE5
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          peak_r[g] <= prot_cfg_pkg::PEAK_RST; // RULE6
        end else begin
          peak_r[g] <= peak_nxt[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped codes answer zero with the error flag.
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = 1'b0;
    rd_error_nxt = 1'b0;
    if (rd_strobe) begin
      rd_valid_nxt = 1'b1;
      case (cmd_code)
        prot_cfg_pkg::CMD_SETUP:     rd_data_nxt = setup_r;
        prot_cfg_pkg::CMD_AVERAGING: rd_data_nxt = {8'h00, avg_r};
        prot_cfg_pkg::CMD_VIN_MAX:   rd_data_nxt = {6'h00, peak_r[0]}; // RULE17
        prot_cfg_pkg::CMD_IOUT_MAX:  rd_data_nxt = {6'h00, peak_r[1]}; // RULE17
        prot_cfg_pkg::CMD_PEAK_PIN:  rd_data_nxt = {6'h00, peak_r[2]}; // RULE17
        prot_cfg_pkg::CMD_PEAK_TEMP: rd_data_nxt = {6'h00, peak_r[3]}; // RULE17
        prot_cfg_pkg::CMD_PEAK_VOUT: rd_data_nxt = {6'h00, peak_r[4]}; // RULE17
        default: begin
          rd_data_nxt  = 16'h0000;
          rd_error_nxt = 1'b1;
        end
      endcase
    end
  end

  // Registers the read answer.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
      rd_error_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_error_r <= rd_error_nxt;
    end
  end

  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign rd_error = rd_error_r;

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // Field decode of the setup word and averaging byte into settings; all come straight from registers through tables or direct decodes.
  logic [1:0] sev_f, ss_f, good_level_sel, mod_f, input_overvolt_level_sel, alert_f, startup_current_limit_sel;
  logic [3:0] report_f;

  assign sev_f          = setup_r[prot_cfg_pkg::SEVERE_FILT_HI:prot_cfg_pkg::SEVERE_FILT_LO];
  assign ss_f           = setup_r[prot_cfg_pkg::SS_DLY_HI:prot_cfg_pkg::SS_DLY_LO];
  assign good_level_sel = setup_r[prot_cfg_pkg::GOOD_LVL_HI:prot_cfg_pkg::GOOD_LVL_LO];
  assign mod_f          = setup_r[prot_cfg_pkg::MOD_TMO_HI:prot_cfg_pkg::MOD_TMO_LO];
  assign input_overvolt_level_sel = setup_r[prot_cfg_pkg::OVP_LVL_HI:prot_cfg_pkg::OVP_LVL_LO];
  assign alert_f        = setup_r[prot_cfg_pkg::ALERT_AVG_HI:prot_cfg_pkg::ALERT_AVG_LO];
  assign report_f       = avg_r[prot_cfg_pkg::REPORT_AVG_HI:prot_cfg_pkg::REPORT_AVG_LO]; // RULE2
  assign startup_current_limit_sel = avg_r[prot_cfg_pkg::SU_LIMIT_HI:prot_cfg_pkg::SU_LIMIT_LO];

  // Table lookups for the timing and threshold settings.
  always_comb begin
    case (sev_f) // RULE7
      2'h1:    severe_filter_cycles = prot_cfg_pkg::SEVERE_CYC1;
      2'h2:    severe_filter_cycles = prot_cfg_pkg::SEVERE_CYC2;
      2'h3:    severe_filter_cycles = prot_cfg_pkg::SEVERE_CYC3;
      default: severe_filter_cycles = 12'h000;
    endcase
    case (ss_f) // RULE9
      2'h1:    soft_start_delay_ms = 5'(prot_cfg_pkg::SS_MS1);
      2'h2:    soft_start_delay_ms = 5'(prot_cfg_pkg::SS_MS2);
      default: soft_start_delay_ms = 5'h00; // Unused code 3 behaves as no delay.
    endcase
    moderate_timeout_ms = 8'h00;
    moderate_timeout_us = 7'h00;
    case (mod_f) // RULE12 RULE13
      2'h1:    moderate_timeout_ms = 8'(prot_cfg_pkg::MOD_MS1);
      2'h2:    moderate_timeout_ms = 8'(prot_cfg_pkg::MOD_MS2);
      2'h3: begin
        if (POWER_VARIANT) moderate_timeout_ms = 8'(prot_cfg_pkg::POWER_FAST_MS);
        else moderate_timeout_us = 7'(prot_cfg_pkg::MOD_US3);
      end
      default: begin
        if (POWER_VARIANT) moderate_timeout_ms = 8'(prot_cfg_pkg::POWER_FAST_MS);
        else moderate_timeout_us = 7'(prot_cfg_pkg::MOD_US0);
      end
    endcase
    case (startup_current_limit_sel) // RULE4
      2'h1:    startup_current_amps = prot_cfg_pkg::SU_A1;
      2'h2:    startup_current_amps = prot_cfg_pkg::SU_A2;
      2'h3:    startup_current_amps = prot_cfg_pkg::SU_A3;
      default: startup_current_amps = prot_cfg_pkg::SU_A0;
    endcase
  end

  // Direct bit and arithmetic decodes.
  assign current_conv_enable   = ~setup_r[prot_cfg_pkg::IADC_OFF_BIT]; // RULE8
  assign good_level_volts      = prot_cfg_pkg::GOOD_V0 - {6'h00, good_level_sel}; // RULE10
  assign self_check_volts      = prot_cfg_pkg::CHECK_V0 - {6'h00, good_level_sel}; // RULE10
  assign severe_ratio_pct      = setup_r[prot_cfg_pkg::SEVERE_RATIO] ? prot_cfg_pkg::RATIO_HI
                                                                     : prot_cfg_pkg::RATIO_LO; // RULE11
  assign input_overvolt_enable = setup_r[prot_cfg_pkg::OVP_EN_BIT]; // RULE14
  assign input_overvolt_volts  = prot_cfg_pkg::OVP_V0
                               + 8'(prot_cfg_pkg::OVP_V_STEP * {6'h00, input_overvolt_level_sel}); // RULE15
  assign alert_avg_samples     = 4'h1 << alert_f; // RULE16
  assign report_avg_samples    = 16'h0001 << report_f; // RULE3

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the registers and their decodes.
  // Reset and holding of the setup word; writing and decodes of the averaging byte.
  setup_reset_a: assert property (@(posedge sys_clk) !rstn |=> setup_r == 16'h0000) // RULE1
    else $error("setup word not zero after reset");

  setup_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
    !(wr_strobe && cmd_code == 8'hD0) |=> setup_r == $past(setup_r))
    else $error("setup word changed without write");

  avg_write_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    wr_strobe && cmd_code == 8'hDD |=> avg_r == $past(wr_data[7:0]))
    else $error("averaging byte write wrong");

  avg_upper_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
    report_avg_samples == (16'h0001 << avg_r[3:0]))
    else $error("upper averaging bits affect report count");

  report_count_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    avg_r[3:0] == 4'hF |-> report_avg_samples == 16'h8000)
    else $error("report averaging count wrong");

  report_one_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    avg_r[3:0] == 4'h0 |-> report_avg_samples == 16'h0001)
    else $error("report averaging default wrong");

  startup_lim_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    avg_r[5:4] == 2'h2 |-> startup_current_amps == 8'h04)
    else $error("startup limit decode wrong");

  startup_dflt_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    avg_r[5:4] == 2'h0 |-> startup_current_amps == 8'h08)
    else $error("startup limit default wrong");

  // Peak capture, wipe and read-back.
  peak_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    sample_valid && !send_strobe && vin_sample > peak_r[0] |=> peak_r[0] == $past(vin_sample))
    else $error("peak did not capture larger sample");

  peak_rise_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    !(send_strobe && cmd_code == 8'hD5) |=> peak_r[3] >= $past(peak_r[3]))
    else $error("peak fell without wipe");

  peak_wipe_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    send_strobe && cmd_code == 8'hD5 && !sample_valid |=> peak_r[1] == 10'h000 && peak_r[3] == 10'h000)
    else $error("peak wipe failed");

  wipe_sample_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
    send_strobe && cmd_code == 8'hD5 && sample_valid |=> peak_r[2] == $past(pin_sample))
    else $error("sample lost in wipe cycle");

  peak_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE17
    rd_strobe && cmd_code == 8'hFD |=> rd_valid && rd_data == {6'h00, $past(peak_r[4])})
    else $error("peak read wrong");

  read_vin_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE17
    rd_strobe && cmd_code == 8'hD1 |=> rd_valid && !rd_error && rd_data == {6'h00, $past(peak_r[0])})
    else $error("input voltage peak read wrong");

  read_err_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE17
    rd_strobe && cmd_code == 8'hD6 |=> rd_valid && rd_error && rd_data == 16'h0000)
    else $error("unmapped read not refused");

  // Field decodes of the setup word.
  severe_filt_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    sev_f == 2'h3 |-> severe_filter_cycles == 12'h4E2)
    else $error("severe deglitch count wrong");

  severe_one_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    sev_f == 2'h1 |-> severe_filter_cycles == 12'h07D)
    else $error("short deglitch count wrong");

  setup_write_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    wr_strobe && cmd_code == 8'hD0 |=> current_conv_enable == !$past(wr_data[13]))
    else $error("current conversion enable wrong");

  conv_off_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    setup_r[13] |-> !current_conv_enable)
    else $error("conversion not disabled");

  soft_start_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    ss_f == 2'h2 |-> soft_start_delay_ms == 5'h14)
    else $error("soft-start delay wrong");

  soft_ten_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    ss_f == 2'h1 |-> soft_start_delay_ms == 5'h0A)
    else $error("short soft-start delay wrong");

  good_pair_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    good_level_volts - self_check_volts == 8'h02)
    else $error("threshold pair wrong");

  good_top_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    good_level_sel == 2'h3 |-> good_level_volts == 8'h08 && self_check_volts == 8'h06)
    else $error("lowest threshold pair wrong");

  severe_ratio_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
    severe_ratio_pct == (setup_r[7] ? 8'hAA : 8'h82))
    else $error("severe ratio wrong");

  moderate_dflt_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12 RULE13
    mod_f == 2'h0 |-> (POWER_VARIANT ? moderate_timeout_ms == 8'h04 : moderate_timeout_us == 7'h64))
    else $error("default timeout wrong");

  ovp_write_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE14
    wr_strobe && cmd_code == 8'hD0 |=> input_overvolt_enable == $past(wr_data[4]))
    else $error("overvoltage enable wrong");

  ovp_level_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    input_overvolt_level_sel == 2'h2 |-> input_overvolt_volts == 8'h12)
    else $error("overvoltage threshold wrong");

  ovp_dflt_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE15
    input_overvolt_level_sel == 2'h0 |-> input_overvolt_volts == 8'h0E)
    else $error("default overvoltage threshold wrong");

  alert_top_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE16
    alert_f == 2'h3 |-> alert_avg_samples == 4'h8)
    else $error("warning averaging wrong");

endmodule : protection_config_registers

// ==== design/prot_cfg_pkg.sv ====
/*
  Holds command codes, field positions, reset values and decoded setting tables for the protection
  configuration register bank.
  Assumes a PMBus-style command decoder outside that presents command codes and data bytes as strobes.
*/
package prot_cfg_pkg;

  // Command codes of the register bank.
  localparam logic [7:0] CMD_SETUP      = 8'hD0;
  localparam logic [7:0] CMD_VIN_MAX    = 8'hD1;
  localparam logic [7:0] CMD_IOUT_MAX   = 8'hD2;
  localparam logic [7:0] CMD_PEAK_PIN   = 8'hD3;
  localparam logic [7:0] CMD_PEAK_TEMP  = 8'hD4;
  localparam logic [7:0] CMD_PEAK_WIPE  = 8'hD5;
  localparam logic [7:0] CMD_AVERAGING  = 8'hDD;
  localparam logic [7:0] CMD_PEAK_VOUT  = 8'hFD;

  // Reset values.
  localparam logic [15:0] SETUP_RST     = 16'h0000;
  localparam logic [7:0]  AVERAGING_RST = 8'h00;
  localparam logic [9:0]  PEAK_RST      = 10'h000;

  // Field positions of the protection setup word.
  localparam int SEVERE_FILT_HI = 15;
  localparam int SEVERE_FILT_LO = 14;
  localparam int IADC_OFF_BIT   = 13;
  localparam int SS_DLY_HI      = 12;
  localparam int SS_DLY_LO      = 11;
  localparam int GOOD_LVL_HI    = 9;
  localparam int GOOD_LVL_LO    = 8;
  localparam int SEVERE_RATIO   = 7;
  localparam int MOD_TMO_HI     = 6;
  localparam int MOD_TMO_LO     = 5;
  localparam int OVP_EN_BIT     = 4;
  localparam int OVP_LVL_HI     = 3;
  localparam int OVP_LVL_LO     = 2;
  localparam int ALERT_AVG_HI   = 1;
  localparam int ALERT_AVG_LO   = 0;

  // Field positions of the averaging setup byte.
  localparam int REPORT_AVG_HI  = 3;
  localparam int REPORT_AVG_LO  = 0;
  localparam int SU_LIMIT_HI    = 5;
  localparam int SU_LIMIT_LO    = 4;

  // Severe deglitch times in microseconds, and their cycle counts at 125 MHz.
  localparam int CLK_MHZ        = 125;
  localparam int SEVERE_US1     = 1;
  localparam int SEVERE_US2     = 2;
  localparam int SEVERE_US3     = 10;
  localparam logic [11:0] SEVERE_CYC1 = 12'(SEVERE_US1 * CLK_MHZ);
  localparam logic [11:0] SEVERE_CYC2 = 12'(SEVERE_US2 * CLK_MHZ);
  localparam logic [11:0] SEVERE_CYC3 = 12'(SEVERE_US3 * CLK_MHZ);

  // Soft-start delays in milliseconds.
  localparam int SS_MS1         = 10;
  localparam int SS_MS2         = 20;

  // Moderate timeouts: microsecond and millisecond figures.
  localparam int MOD_US0        = 100;
  localparam int MOD_MS1        = 250;
  localparam int MOD_MS2        = 100;
  localparam int MOD_US3        = 10;
  localparam int POWER_FAST_MS  = 4;

  // Thresholds in volts and amperes, and severe ratio in percent.
  localparam logic [7:0] GOOD_V0 = 8'h0B;
  localparam logic [7:0] CHECK_V0 = 8'h09;
  localparam logic [7:0] OVP_V0  = 8'h0E;
  localparam logic [7:0] OVP_V_STEP = 8'h02;
  localparam logic [7:0] RATIO_LO = 8'h82;
  localparam logic [7:0] RATIO_HI = 8'hAA;
  localparam logic [7:0] SU_A0 = 8'h08;
  localparam logic [7:0] SU_A1 = 8'h0C;
  localparam logic [7:0] SU_A2 = 8'h04;
  localparam logic [7:0] SU_A3 = 8'h10;

endpackage : prot_cfg_pkg

// ==== verif/pmbus_host_model.sv ====
/*
  Host-side command model that issues write, send-byte and read transfers to the register bank.
  Assumes the bank takes strobes on the rising clock edge and answers a read one cycle later.
*/
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        sys_clk,
  output logic      [7:0]  cmd_code,
  output logic             wr_strobe,
  output logic      [15:0] wr_data,
  output logic             send_strobe,
  output logic             rd_strobe,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_error
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle state at time zero; no strobe is raised before reset is released.
  initial begin
    cmd_code    = 8'h00;
    wr_data     = 16'h0000;
    wr_strobe   = 1'b0;
    send_strobe = 1'b0;
    rd_strobe   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One transfer: kind 0 writes, 1 sends a byte command, 2 reads. The read answer is taken at the
  // falling edge after the taking edge, while the one-cycle valid pulse stands.
  task automatic xfer(input logic [1:0] kind, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rdata, output logic [1:0] flags);
    @(negedge sys_clk);
    cmd_code    = code;
    wr_data     = data;
    wr_strobe   = (kind == 2'h0);
    send_strobe = (kind == 2'h1);
    rd_strobe   = (kind == 2'h2);
    @(negedge sys_clk);
    rdata       = rd_data;
    flags       = {rd_valid, rd_error};
    wr_strobe   = 1'b0;
    send_strobe = 1'b0;
    rd_strobe   = 1'b0;
    // Released lines show the inverse so a stale value can never pass for a live one.
    cmd_code    = ~code;
    wr_data     = ~data;
  endtask : xfer
endmodule : pmbus_host_model

// ==== verif/protection_config_registers_tb_top.sv ====
/*
  Self-checking bench for the protection configuration register bank, current and power variants.
  Assumes the host model drives all command strobes and the bench drives telemetry samples.
*/
`timescale 1ns/1ps
module protection_config_registers_tb_top;
  logic sys_clk, rstn, wr_strobe, send_strobe, rd_strobe, rd_valid, rd_error, sample_valid;
  logic [7:0]  cmd_code, good_v, check_v, ratio, mod_ms, pwr_ms, ovp_v, su_amps;
  logic [15:0] wr_data, rd_data, rep_avg;
  logic [9:0]  vin, iout, pin, temp, vout;
  logic [11:0] sev_cyc;
  logic [6:0]  mod_us;
  logic [4:0]  ss_ms;
  logic [3:0]  alert_avg;
  logic        conv_en, ovp_en;
  int          failures, check_count, cycles;

  ////////////////////////////////////////////////////////////////////////////////
  // Both variants share the inputs; only the timeout of the power variant is watched.
  protection_config_registers #(.POWER_VARIANT(1'b0)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data), .send_strobe(send_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error),
    .sample_valid(sample_valid), .vin_sample(vin), .iout_sample(iout), .pin_sample(pin),
    .temp_sample(temp), .vout_sample(vout), .severe_filter_cycles(sev_cyc), .current_conv_enable(conv_en),
    .soft_start_delay_ms(ss_ms), .good_level_volts(good_v), .self_check_volts(check_v),
    .severe_ratio_pct(ratio), .moderate_timeout_ms(mod_ms), .moderate_timeout_us(mod_us),
    .input_overvolt_enable(ovp_en), .input_overvolt_volts(ovp_v), .alert_avg_samples(alert_avg),
    .report_avg_samples(rep_avg), .startup_current_amps(su_amps));
  protection_config_registers #(.POWER_VARIANT(1'b1)) dut_pwr (.sys_clk(sys_clk), .rstn(rstn),
    .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data), .send_strobe(send_strobe),
    .rd_strobe(rd_strobe), .rd_data(), .rd_valid(), .rd_error(), .sample_valid(sample_valid),
    .vin_sample(vin), .iout_sample(iout), .pin_sample(pin), .temp_sample(temp), .vout_sample(vout),
    .severe_filter_cycles(), .current_conv_enable(), .soft_start_delay_ms(), .good_level_volts(),
    .self_check_volts(), .severe_ratio_pct(), .moderate_timeout_ms(pwr_ms), .moderate_timeout_us(),
    .input_overvolt_enable(), .input_overvolt_volts(), .alert_avg_samples(), .report_avg_samples(),
    .startup_current_amps());
  pmbus_host_model host (.sys_clk(sys_clk), .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .send_strobe(send_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 8 ns period and a cycle ceiling that cuts a hang short.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers: comparison, reset, writes, reads and one telemetry sample.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic do_reset();
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
  endtask : do_reset
  task automatic op(input logic [1:0] kind, input logic [7:0] code, input logic [15:0] data);
    logic [15:0] d;
    logic [1:0]  f;
    host.xfer(kind, code, data, d, f);
  endtask : op
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic err);
    logic [15:0] d;
    logic [1:0]  f;
    host.xfer(2'h2, code, 16'h0000, d, f);
    check(d, exp, "read data");
    check(f, {1'b1, err}, "read flags");
  endtask : rd_chk
  task automatic push(input logic [9:0] a, b, c, e, g);
    @(negedge sys_clk);
    {sample_valid, vin, iout, pin, temp, vout} = {1'b1, a, b, c, e, g};
    @(negedge sys_clk);
    sample_valid = 1'b0;
  endtask : push

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic test_reset();
    rd_chk(prot_cfg_pkg::CMD_SETUP, 16'h0000, 1'b0);
    check({conv_en, ovp_en, ss_ms, mod_us}, {1'b1, 1'b0, 5'h00, 7'h64}, "default decode");
    check({ratio, ovp_v, alert_avg}, {8'h82, 8'h0E, 4'h1}, "default levels");
    $display("test_reset done");
  endtask : test_reset
  task automatic test_setup();
    int sev[4] = '{0, 125, 250, 1250};
    int ms[4] = '{0, 250, 100, 0};
    int us[4] = '{100, 0, 0, 10};
    int pms[4] = '{4, 250, 100, 4};
    logic [1:0] c, s;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      s = (c == 2'h3) ? 2'h0 : c;
      w = {c, c[0], s, 1'b0, c, c[0], c, c[0], s, c};
      op(2'h0, prot_cfg_pkg::CMD_SETUP, w);
      check(sev_cyc, sev[i], "deglitch");
      check(conv_en, !c[0], "conversion");
      check(ss_ms, 10 * s, "soft start");
      check({good_v, check_v}, {8'(11 - i), 8'(9 - i)}, "good level");
      check(ratio, c[0] ? 170 : 130, "severe ratio");
      check({mod_ms, mod_us}, {8'(ms[i]), 7'(us[i])}, "moderate timeout");
      check(pwr_ms, pms[i], "power timeout");
      check(ovp_en, c[0], "overvolt enable");
      check(ovp_v, 14 + 2 * s, "overvolt level");
      check(alert_avg, 1 << i, "alert averaging");
      rd_chk(prot_cfg_pkg::CMD_SETUP, w, 1'b0);
    end
    $display("test_setup done");
  endtask : test_setup
  task automatic test_avg();
    int amps[4] = '{8, 12, 4, 16};
    logic [7:0] b;
    for (int n = 0; n < 16; n++) begin
      b = {n[0], n[0], n[3:2], n[3:0]};
      op(2'h0, prot_cfg_pkg::CMD_AVERAGING, {8'hA5, b});
      check(rep_avg, 1 << n, "report averaging");
      check(su_amps, amps[n[3:2]], "startup limit");
      rd_chk(prot_cfg_pkg::CMD_AVERAGING, {8'h00, b}, 1'b0);
    end
    $display("test_avg done");
  endtask : test_avg
  task automatic test_peaks();
    push(10'h064, 10'h0C8, 10'h12C, 10'h190, 10'h1F4);
    push(10'h032, 10'h384, 10'h00A, 10'h3FF, 10'h014);
    op(2'h0, prot_cfg_pkg::CMD_VIN_MAX, 16'h03FF);
    rd_chk(prot_cfg_pkg::CMD_VIN_MAX, 16'h0064, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_IOUT_MAX, 16'h0384, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_PEAK_PIN, 16'h012C, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_PEAK_TEMP, 16'h03FF, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_PEAK_VOUT, 16'h01F4, 1'b0);
    rd_chk(8'hD6, 16'h0000, 1'b1);
    op(2'h1, prot_cfg_pkg::CMD_PEAK_TEMP, 16'h0000);
    rd_chk(prot_cfg_pkg::CMD_PEAK_TEMP, 16'h03FF, 1'b0);
    op(2'h1, prot_cfg_pkg::CMD_PEAK_WIPE, 16'h0000);
    rd_chk(prot_cfg_pkg::CMD_IOUT_MAX, 16'h0000, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_PEAK_VOUT, 16'h0000, 1'b0);
    push(10'h011, 10'h022, 10'h033, 10'h044, 10'h055);
    do_reset();
    rd_chk(prot_cfg_pkg::CMD_PEAK_PIN, 16'h0000, 1'b0);
    rd_chk(prot_cfg_pkg::CMD_SETUP, 16'h0000, 1'b0);
    $display("test_peaks done");
  endtask : test_peaks

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report; the only place the run ends.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rstn, sample_valid, vin, iout, pin, temp, vout} = '0;
    {failures, check_count, cycles} = '0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    test_reset();
    test_setup();
    test_avg();
    test_peaks();
    print_verdict();
  end
endmodule : protection_config_registers_tb_top
